// *** src/cbm_pkg.sv ***
// package for the call/branch/move execution slice of an 8-bit core
// assumes a 14-bit instruction word, single instruction clock
package cbm_pkg;
  // ===========================================================================
  // widths
  localparam int unsigned INSTR_W    = 14;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FILE_AW    = 7;
  localparam int unsigned PAGE_AW    = 4;
  localparam int unsigned STACK_LVLS = 8;
  localparam int unsigned SP_W       = 3;
  // ===========================================================================
  // control-page address window
  localparam logic [3:0] PAGE_ADDR_MIN = 4'h5;
  localparam logic [3:0] PAGE_ADDR_MAX = 4'hf;
  // ===========================================================================
  // opcode matching: (instr & mask) == match
  localparam logic [13:0] OPM_PAGE   = 14'h3ff0;
  localparam logic [13:0] OPC_PAGE   = 14'h0000;
  localparam logic [13:0] OPM_CALL   = 14'h3800;
  localparam logic [13:0] OPC_CALL   = 14'h3000;
  localparam logic [13:0] OPM_JUMP   = 14'h3800;
  localparam logic [13:0] OPC_JUMP   = 14'h3800;
  localparam logic [13:0] OPM_MOVI   = 14'h3f00;
  localparam logic [13:0] OPC_MOVI   = 14'h1e00;
  localparam logic [13:0] OPM_MOVE_WORK_TO_FILE  = 14'h3f80;
  localparam logic [13:0] OPC_MOVE_WORK_TO_FILE  = 14'h0080;
  localparam logic [13:0] OPM_MOVE_FILE_TO_TARGET   = 14'h3f00;
  localparam logic [13:0] OPC_MOVE_FILE_TO_TARGET   = 14'h0800;
  localparam int unsigned DEST_BIT   = 7;
  // ===========================================================================
  // reset values
  localparam logic [10:0] PTR_RST    = 11'h000;
  localparam logic [7:0]  WORK_RST   = 8'h00;
  localparam logic [2:0]  SP_RST     = 3'h0;

  typedef enum logic [2:0] {
    CBM_NONE, CBM_PAGE, CBM_CALL, CBM_JUMP, CBM_MOVI, CBM_MOVE_WORK_TO_FILE, CBM_MOVE_FILE_TO_TARGET
  } cbm_op_e;

  // file / control-page write request
  typedef struct packed {
    logic       file_we;
    logic [6:0] file_addr;
    logic [7:0] file_wdata;
    logic       page_we;
    logic [3:0] page_addr;
    logic [7:0] page_wdata;
  } cbm_wr_s;
endpackage : cbm_pkg

// *** src/cbm_decode.sv ***
// opcode classifier for the executed subset
// assumes a combinational consumer on the same clock
module cbm_decode (
  input  wire logic [13:0]     i_instr,
  output cbm_pkg::cbm_op_e     o_op
);
  always_comb begin
    if ((i_instr & cbm_pkg::OPM_JUMP) == cbm_pkg::OPC_JUMP) begin
      o_op = cbm_pkg::CBM_JUMP;
    end else if ((i_instr & cbm_pkg::OPM_CALL) == cbm_pkg::OPC_CALL) begin
      o_op = cbm_pkg::CBM_CALL;
    end else if ((i_instr & cbm_pkg::OPM_MOVI) == cbm_pkg::OPC_MOVI) begin
      o_op = cbm_pkg::CBM_MOVI;
    end else if ((i_instr & cbm_pkg::OPM_MOVE_FILE_TO_TARGET) == cbm_pkg::OPC_MOVE_FILE_TO_TARGET) begin
      o_op = cbm_pkg::CBM_MOVE_FILE_TO_TARGET;
    end else if ((i_instr & cbm_pkg::OPM_MOVE_WORK_TO_FILE) == cbm_pkg::OPC_MOVE_WORK_TO_FILE) begin
      o_op = cbm_pkg::CBM_MOVE_WORK_TO_FILE;
    end else if ((i_instr & cbm_pkg::OPM_PAGE) == cbm_pkg::OPC_PAGE
                 && i_instr[3:0] >= cbm_pkg::PAGE_ADDR_MIN) begin
      o_op = cbm_pkg::CBM_PAGE;
    end else begin
      o_op = cbm_pkg::CBM_NONE;
    end
  end
endmodule : cbm_decode

// *** src/cbm_exec.sv ***
// execution slice: control-page write, long call, long jump, three moves
// assumes program memory returns i_instr for o_iptr_q one cycle later and
// the file array returns i_file_rdata combinationally for the operand
// Overview of operation
// - control-page write copies working reg to page reg 5..15, one cycle
// - long call pushes its own address plus one (the current instruction pointer) onto the return stack
// - long call loads 11-bit target, two cycles, flags unchanged
// - long call advances stack pointer one level; pushed value is new top
// - long jump loads 11-bit target, two cycles, stack and flags untouched
// - move immediate loads 8-bit value into working reg, one cycle
// - move-to-file writes working reg to file reg 0..127, one cycle
// - move-file writes value to working reg (d=0) or back to file (d=1)
// - move-file sets zero flag from moved value whatever the destination
module cbm_exec #(
  parameter int unsigned STACK_LVLS = cbm_pkg::STACK_LVLS
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic [13:0]          i_instr,
  input  wire logic [7:0]           i_file_rdata,
  output logic      [10:0]          o_iptr_q,
  output logic      [7:0]           o_work_q,
  output logic                      o_zero_q,
  output logic      [2:0]           o_sp_q,
  output logic      [10:0]          o_tos_q,
  output logic                      o_bubble_q,
  output cbm_pkg::cbm_wr_s          o_wr_q
);
  // ===========================================================================
  // decode
  cbm_pkg::cbm_op_e op;
  logic [10:0]      stack_q [STACK_LVLS];
  logic             exec;
  logic [10:0]      pc_of_instr;
  logic [2:0]       sp_inc;

  cbm_decode u_dec (
    .i_instr (i_instr),
    .o_op    (op)
  );

  // the word on i_instr was fetched from the previous pointer value
  assign exec        = !o_bubble_q;
  assign pc_of_instr = o_iptr_q - 11'h001;
  assign sp_inc      = o_sp_q + 3'h1;

  // ===========================================================================
  // instruction pointer and bubble
  // the word fetched behind a transfer is dropped rather than stalled on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_iptr_q   <= cbm_pkg::PTR_RST;
      o_bubble_q <= 1'b1;
    end else if (exec && (op == cbm_pkg::CBM_CALL ||
                          op == cbm_pkg::CBM_JUMP)) begin
      o_iptr_q   <= i_instr[10:0];
      o_bubble_q <= 1'b1;
    end else begin
      o_iptr_q   <= o_iptr_q + 11'h001;
      o_bubble_q <= 1'b0;
    end
  end

  // ===========================================================================
  // return stack; overflow wraps, depth limit is the caller's business
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sp_q  <= cbm_pkg::SP_RST;
      o_tos_q <= cbm_pkg::PTR_RST;
    end else if (exec && op == cbm_pkg::CBM_CALL) begin
      o_sp_q  <= sp_inc;
      o_tos_q <= pc_of_instr + 11'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (exec && op == cbm_pkg::CBM_CALL) begin
      stack_q[sp_inc] <= pc_of_instr + 11'h001;
    end
  end

  // ===========================================================================
  // working register and zero flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_work_q <= cbm_pkg::WORK_RST;
    end else if (exec && op == cbm_pkg::CBM_MOVI) begin
      o_work_q <= i_instr[7:0];
    end else if (exec && op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET &&
                 !i_instr[cbm_pkg::DEST_BIT]) begin
      o_work_q <= i_file_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_zero_q <= 1'b0;
    end else if (exec && op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET) begin
      o_zero_q <= (i_file_rdata == 8'h00);
    end
  end

  // ===========================================================================
  // write requests, one-cycle pulses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wr_q <= '0;
    end else begin
      o_wr_q            <= '0;
      o_wr_q.file_addr  <= i_instr[6:0];
      o_wr_q.page_addr  <= i_instr[3:0];
      o_wr_q.page_wdata <= o_work_q;
      o_wr_q.file_wdata <= (op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET) ? i_file_rdata
                                                       : o_work_q;
      if (exec && op == cbm_pkg::CBM_PAGE) begin
        o_wr_q.page_we <= 1'b1;
      end
      if (exec && (op == cbm_pkg::CBM_MOVE_WORK_TO_FILE ||
                   (op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET &&
                    i_instr[cbm_pkg::DEST_BIT]))) begin
        o_wr_q.file_we <= 1'b1;
      end
    end
  end

  // ===========================================================================
  // checks: control page and moves
  page_write_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_PAGE |=> o_wr_q.page_we &&
      o_wr_q.page_wdata == $past(o_work_q) &&
      o_wr_q.page_addr == $past(i_instr[3:0]) &&
      o_wr_q.page_addr >= cbm_pkg::PAGE_ADDR_MIN && $stable(o_zero_q))
    else $error("page write wrong");

  page_refuse_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && (i_instr & cbm_pkg::OPM_PAGE) == cbm_pkg::OPC_PAGE &&
      i_instr[3:0] < cbm_pkg::PAGE_ADDR_MIN |=> !o_wr_q.page_we)
    else $error("page write below window");

  move_imm_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_MOVI |=> o_work_q == $past(i_instr[7:0])
      && $stable(o_zero_q))
    else $error("immediate move wrong");

  move_file_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_MOVE_WORK_TO_FILE |=> o_wr_q.file_we &&
      o_wr_q.file_wdata == $past(o_work_q) &&
      o_wr_q.file_addr == $past(i_instr[6:0]) && $stable(o_zero_q))
    else $error("work to file wrong");

  move_dest_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET |=>
      o_wr_q.file_we == $past(i_instr[cbm_pkg::DEST_BIT]) &&
      o_zero_q == ($past(i_file_rdata) == 8'h00))
    else $error("file move wrong");

  move_work_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET && !i_instr[cbm_pkg::DEST_BIT] |=>
      o_work_q == $past(i_file_rdata))
    else $error("file to work wrong");

  move_back_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_MOVE_FILE_TO_TARGET && i_instr[cbm_pkg::DEST_BIT] |=>
      $stable(o_work_q) && o_wr_q.file_wdata == $past(i_file_rdata) &&
      o_wr_q.file_addr == $past(i_instr[6:0]))
    else $error("file write back wrong");

  // ===========================================================================
  // checks: call and jump
  call_push_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_CALL |=> o_tos_q == $past(o_iptr_q))
    else $error("call return address wrong");

  call_target_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_CALL |=> o_iptr_q == $past(i_instr[10:0])
      && o_bubble_q && $stable(o_zero_q))
    else $error("call target wrong");

  stack_level_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_CALL |=> o_sp_q == $past(o_sp_q) + 3'h1)
    else $error("stack pointer not advanced");

  stack_top_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_CALL |=> stack_q[o_sp_q] == o_tos_q)
    else $error("pushed address not on top");

  jump_target_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    exec && op == cbm_pkg::CBM_JUMP |=> o_iptr_q == $past(i_instr[10:0])
      && o_bubble_q && $stable(o_sp_q) && $stable(o_tos_q) &&
      $stable(o_zero_q))
    else $error("jump wrong");

  // ===========================================================================
  // checks: the dropped word
  bubble_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_bubble_q |=> !o_wr_q.page_we && !o_wr_q.file_we && !o_bubble_q)
    else $error("bubble executed");

  bubble_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_bubble_q |=> $stable(o_work_q) && $stable(o_zero_q) &&
      $stable(o_sp_q) && $stable(o_tos_q))
    else $error("bubble changed state");

  bubble_step_a: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_bubble_q |=> o_iptr_q == $past(o_iptr_q) + 11'h001)
    else $error("bubble did not resume at target");
endmodule : cbm_exec

// *** tb/cbm_exec_tb.sv ***
// testbench for the call/branch/move execution slice
// assumes the bench stands in for program memory and the file array
module cbm_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin samples_checked++; \
  if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
  // ===========================================================================
  // signals and model state
  logic              i_clk = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [13:0]       i_instr = 14'h0000;
  logic [7:0]        i_file_rdata = 8'h00;
  logic [10:0]       o_iptr_q;
  logic [10:0]       o_tos_q;
  logic [7:0]        o_work_q;
  logic              o_zero_q;
  logic              o_bubble_q;
  logic [2:0]        o_sp_q;
  cbm_pkg::cbm_wr_s  o_wr_q;
  logic [10:0]       m_ip;
  logic [10:0]       m_tos;
  logic [7:0]        m_w;
  logic              m_z;
  logic              m_bub;
  logic [2:0]        m_sp;
  cbm_pkg::cbm_wr_s  m_wr;
  int                n_fail = 0;
  int                samples_checked = 0;
  int                seed = 23119;

  always #5 i_clk = ~i_clk;

  cbm_exec u_cbm_exec (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_instr      (i_instr),
    .i_file_rdata (i_file_rdata),
    .o_iptr_q     (o_iptr_q),
    .o_work_q     (o_work_q),
    .o_zero_q     (o_zero_q),
    .o_sp_q       (o_sp_q),
    .o_tos_q      (o_tos_q),
    .o_bubble_q   (o_bubble_q),
    .o_wr_q       (o_wr_q)
  );
  // ===========================================================================
  // tasks
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check;
    `CHK(o_iptr_q, m_ip)
    `CHK(o_work_q, m_w)
    `CHK(o_zero_q, m_z)
    `CHK(o_sp_q, m_sp)
    `CHK(o_tos_q, m_tos)
    `CHK(o_bubble_q, m_bub)
    `CHK(o_wr_q.page_we, m_wr.page_we)
    `CHK(o_wr_q.file_we, m_wr.file_we)
    if (m_wr.page_we) `CHK(o_wr_q.page_addr, m_wr.page_addr)
    if (m_wr.page_we) `CHK(o_wr_q.page_wdata, m_wr.page_wdata)
    if (m_wr.file_we) `CHK(o_wr_q.file_addr, m_wr.file_addr)
    if (m_wr.file_we) `CHK(o_wr_q.file_wdata, m_wr.file_wdata)
  endtask : check

  // reset asserted off the edge, released three edges later
  task automatic do_reset;
    i_rst_n = 1'b0;
    {m_ip, m_tos, m_w, m_z, m_sp} = '0;
    m_bub = 1'b1;
    m_wr = '0;
    repeat (3) @(posedge i_clk);
    #1;
    check();
    i_rst_n = 1'b1;
  endtask : do_reset

  // random word of one of the six kinds; words in a bubble must be ignored
  task automatic step;
    int          k;
    logic [13:0] w;
    logic [10:0] a;
    logic [7:0]  r;
    k = $unsigned($random(seed)) % 6;
    w = 14'($random(seed));
    case (k)
      0: w = {10'h000, w[3:0]};
      1: w = {7'h01, w[6:0]};
      2: w = {6'h08, w[7:0]};
      3: w = {6'h1e, w[7:0]};
      4: w = {3'h6, w[10:0]};
      default: w = {3'h7, w[10:0]};
    endcase
    i_instr = w;
    r = 8'($random(seed));
    // zero data is rare in a plain random byte; force it a quarter of the time
    if ($random(seed) % 4 == 0) r = 8'h00;
    i_file_rdata = r;
    m_wr.file_we = 1'b0;
    m_wr.page_we = 1'b0;
    a = m_ip;
    m_ip = a + 11'h001;
    if (m_bub) begin
      m_bub = 1'b0;
    end else begin
      case (k)
        0: if (w[3:0] >= 4'h5) begin
          m_wr.page_we = 1'b1;
          m_wr.page_addr = w[3:0];
          m_wr.page_wdata = m_w;
        end
        1: begin
          m_wr.file_we = 1'b1;
          m_wr.file_addr = w[6:0];
          m_wr.file_wdata = m_w;
        end
        2: begin
          m_z = (i_file_rdata == 8'h00);
          if (w[7]) begin
            m_wr.file_we = 1'b1;
            m_wr.file_addr = w[6:0];
            m_wr.file_wdata = i_file_rdata;
          end else m_w = i_file_rdata;
        end
        3: m_w = w[7:0];
        4: begin
          m_tos = a;
          m_sp = m_sp + 3'h1;
          m_ip = w[10:0];
          m_bub = 1'b1;
        end
        default: begin
          m_ip = w[10:0];
          m_bub = 1'b1;
        end
      endcase
    end
  endtask : step
  // ===========================================================================
  // main sequence: second reset in mid-run
  initial begin
    do_reset();
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) do_reset();
      step();
      @(posedge i_clk);
      #1;
      check();
    end
    tally_and_finish();
  end
endmodule : cbm_exec_tb
